// ### logic/touch_pkg.sv
// Constants, register map and carrier type for the touch sense controller
package touch_pkg;
   localparam int NUM_IN = 6;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h03;
   localparam logic [7:0] OFS_NOISE = 8'h0A;
   localparam logic [7:0] OFS_CONFIG = 8'h20;
   localparam logic [7:0] OFS_ENABLE = 8'h21;
   localparam logic [7:0] OFS_DUR = 8'h22;
   localparam logic [7:0] OFS_PRESS = 8'h23;
   localparam logic [7:0] OFS_SAMPLE = 8'h24;
   localparam logic [7:0] OFS_RECAL = 8'h26;
   localparam logic [7:0] OFS_REPEAT = 8'h28;
   localparam logic [7:0] OFS_PCOUNT = 8'h2A;
   localparam logic [7:0] OFS_PATTERN = 8'h2D;
   localparam logic [7:0] OFS_NEGCFG = 8'h2F;
   localparam logic [7:0] OFS_THRESH = 8'h30;
   localparam logic [7:0] OFS_BASE = 8'h50;
   localparam logic [7:0] OFS_LINK = 8'h80;
   localparam logic [7:0] RST_ENABLE = 8'h3F;
   localparam logic [7:0] RST_CONFIG = 8'h20;
   localparam logic [7:0] RST_DUR = 8'hA4;
   localparam logic [7:0] RST_PRESS = 8'h07;
   localparam logic [7:0] RST_SAMPLE = 8'h00;
   localparam logic [7:0] RST_REPEAT = 8'h3F;
   localparam logic [7:0] RST_PCOUNT = 8'h80;
   localparam logic [7:0] RST_PATTERN = 8'h3F;
   localparam logic [7:0] RST_NEGCFG = 8'h8A;
   localparam logic [7:0] RST_THRESH = 8'h40;
   localparam logic [7:0] RST_RECAL = 8'h00;
   localparam int BIT_INT = 0;
   localparam int BIT_POL = 1;
   localparam int BIT_STUCK_EN = 3;
   localparam int BIT_REL_EN = 5;
   localparam int BIT_PAT_IRQ = 2;
   localparam int BIT_PAT_MODE = 7;
   localparam int AVG_SHIFT = 6;
   localparam int RECAL_TIME_MS = 200;
   localparam int CLK_HZ = 10_000_000;
   localparam int RECAL_CYCLES = RECAL_TIME_MS * (CLK_HZ / 1000);
   localparam int TICK_CYCLES = 100_000;
   typedef struct packed {
      logic valid;
      logic [7:0] count;
      logic lf_noise;
      logic rf_noise;
   } sample_s;
endpackage

// ### logic/touch_sense_controller.sv
// Touch sense controller: scan, baseline compare, recalibration, alert and AHB-Lite registers
//
// Added by the designer: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
module touch_sense_controller #(
   parameter int RECAL_LEN = touch_pkg::RECAL_CYCLES,
   parameter int TICK_LEN = touch_pkg::TICK_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic [2:0] meas_sel,
   output logic meas_start,
   input wire logic meas_done,
   input wire logic [7:0] meas_count,
   input wire logic lf_noise,
   input wire logic rf_noise,
   output logic alert,
   output logic [1:0] driver_actuate
);
   localparam int N = touch_pkg::NUM_IN;
   typedef enum logic [1:0] {SCAN_PICK, SCAN_MEAS, SCAN_EVAL} scan_e;

   function automatic logic [2:0] popcount(input logic [5:0] v);
      logic [2:0] c;
      c = 3'h0;
      for (int i = 0; i < N; i++) begin
         c = c + {2'h0, v[i]};
      end
      return c;
   endfunction

   // Synchronised measurement inputs
   touch_pkg::sample_s s1_reg, s2_reg;
   logic done1_reg, done2_reg, done3_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_reg <= '0;
         s2_reg <= '0;
         done1_reg <= 1'b0;
         done2_reg <= 1'b0;
         done3_reg <= 1'b0;
      end else begin
         s1_reg <= '{valid: 1'b0, count: meas_count, lf_noise: lf_noise, rf_noise: rf_noise};
         s2_reg <= s1_reg;
         done1_reg <= meas_done;
         done2_reg <= done1_reg;
         done3_reg <= done2_reg;
      end
   end
   wire done_pulse = done2_reg & ~done3_reg;

   // Registers
   logic [7:0] ctrl_reg, config_reg, enable_reg, dur_reg, press_reg, sample_reg;
   logic [7:0] recal_reg, repeat_reg, pcount_reg, pattern_reg, negcfg_reg, link_reg;
   logic [7:0] status_reg, noise_reg;
   logic [7:0] thresh_reg [N];
   logic [7:0] base_reg [N];
   logic [15:0] acc_reg [N];
   logic [6:0] avg_n_reg [N];
   logic [3:0] neg_reg [N];
   logic [7:0] held_reg [N];
   logic [3:0] press_cnt_reg [N];
   logic [3:0] rep_cnt_reg [N];
   logic [23:0] cal_cnt_reg [N];
   logic [N-1:0] touch_reg, cal_reg, hold_reg;
   logic [N-1:0] over_pat_reg;
   logic [31:0] tick_cnt_reg;
   logic [7:0] os_cnt_reg;
   logic [2:0] idx_reg;
   scan_e state_reg;
   logic pat_reg;

   // AHB-Lite slave
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg, rd_addr_reg;
   wire take = hsel & hready & htrans[1];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         rd_addr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= take & hwrite;
         if (take) begin
            wr_addr_reg <= haddr[9:2];
            rd_addr_reg <= haddr[9:2];
         end
      end
   end
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   wire [7:0] wdata = hwdata[7:0];
   wire wr_ctrl = wr_pend_reg && wr_addr_reg == touch_pkg::OFS_CTRL;
   wire int_clear = wr_ctrl && !wdata[touch_pkg::BIT_INT];
   wire wr_recal = wr_pend_reg && wr_addr_reg == touch_pkg::OFS_RECAL;

   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      case (rd_addr_reg)
         touch_pkg::OFS_CTRL: rd_mux = ctrl_reg;
         touch_pkg::OFS_STATUS: rd_mux = status_reg;
         touch_pkg::OFS_NOISE: rd_mux = noise_reg;
         touch_pkg::OFS_CONFIG: rd_mux = config_reg;
         touch_pkg::OFS_ENABLE: rd_mux = enable_reg;
         touch_pkg::OFS_DUR: rd_mux = dur_reg;
         touch_pkg::OFS_PRESS: rd_mux = press_reg;
         touch_pkg::OFS_SAMPLE: rd_mux = sample_reg;
         touch_pkg::OFS_RECAL: rd_mux = recal_reg;
         touch_pkg::OFS_REPEAT: rd_mux = repeat_reg;
         touch_pkg::OFS_PCOUNT: rd_mux = pcount_reg;
         touch_pkg::OFS_PATTERN: rd_mux = pattern_reg;
         touch_pkg::OFS_NEGCFG: rd_mux = negcfg_reg;
         touch_pkg::OFS_LINK: rd_mux = link_reg;
         default: begin
            for (int i = 0; i < N; i++) begin
               if (rd_addr_reg == touch_pkg::OFS_THRESH + 8'(i)) rd_mux = thresh_reg[i];
               if (rd_addr_reg == touch_pkg::OFS_BASE + 8'(i)) rd_mux = base_reg[i];
            end
         end
      endcase
   end
   assign hrdata = {24'h000000, rd_mux};

   // Scan evaluation terms
   wire [7:0] cur_base = base_reg[idx_reg];
   wire [7:0] cur_meas = s2_reg.count;
   wire signed [8:0] delta = $signed({1'b0, cur_meas}) - $signed({1'b0, cur_base});
   wire over = !delta[8] && delta[7:0] >= thresh_reg[idx_reg];
   wire negative = delta[8];
   wire noisy = s2_reg.lf_noise | s2_reg.rf_noise;
   wire [7:0] os_target = 8'(1) << sample_reg[2:0];
   wire prox_sel = sample_reg[6:4] == idx_reg;
   wire [7:0] os_need = prox_sel ? os_target : 8'h01;
   wire tick = tick_cnt_reg == 32'(TICK_LEN - 1);
   wire [2:0] pat_count = popcount(over_pat_reg | noise_reg[5:0]);
   wire [5:0] pat_set = over_pat_reg | noise_reg[5:0];
   wire pat_now = pcount_reg[touch_pkg::BIT_PAT_MODE] ?
      (pattern_reg[5:0] != 6'h00 && (pat_set & pattern_reg[5:0]) == pattern_reg[5:0]) :
      (pat_count >= pcount_reg[2:0] + 3'h1);
   wire any_touch = |touch_reg;

   logic [2:0] next_idx;
   logic next_found;
   always_comb begin
      next_idx = 3'h0;
      next_found = 1'b0;
      for (int i = N - 1; i >= 0; i--) begin
         if (enable_reg[i] && 3'(i) >= idx_reg) begin
            next_idx = 3'(i);
            next_found = 1'b1;
         end
      end
   end

   logic [N-1:0] irq_set, touch_next, cal_start;
   always_comb begin
      irq_set = '0;
      touch_next = touch_reg;
      cal_start = '0;
      for (int i = 0; i < N; i++) begin
         if (recal_reg[i] && !cal_reg[i]) cal_start[i] = 1'b1;
         if (config_reg[touch_pkg::BIT_STUCK_EN] && touch_reg[i] &&
             held_reg[i] >= {4'h0, dur_reg[7:4]} && tick) cal_start[i] = 1'b1;
         if (cal_reg[i] || !enable_reg[i]) touch_next[i] = 1'b0;
      end
      if (state_reg == SCAN_EVAL && !noisy && os_cnt_reg + 8'h01 >= os_need &&
          !cal_reg[idx_reg]) begin
         touch_next[idx_reg] = over && !pat_reg;
         if (over && !touch_reg[idx_reg] && !pat_reg) irq_set[idx_reg] = 1'b1;
         if (!over && touch_reg[idx_reg] && config_reg[touch_pkg::BIT_REL_EN])
            irq_set[idx_reg] = 1'b1;
         if (negative && negcfg_reg[7:4] != 4'h0 && neg_reg[idx_reg] + 4'h1 >= negcfg_reg[7:4])
            cal_start[idx_reg] = 1'b1;
      end
      for (int i = 0; i < N; i++) begin
         if (tick && touch_reg[i] && repeat_reg[i] && hold_reg[i] &&
             rep_cnt_reg[i] >= dur_reg[3:0]) irq_set[i] = 1'b1;
      end
   end
   wire pat_irq = pat_now && !pat_reg && pcount_reg[touch_pkg::BIT_PAT_IRQ];
   wire irq_any = |irq_set | pat_irq;

   // Scan sequencer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= SCAN_PICK;
         idx_reg <= 3'h0;
         os_cnt_reg <= 8'h00;
      end else begin
         case (state_reg)
            SCAN_PICK: begin
               if (next_found) begin
                  idx_reg <= next_idx;
                  state_reg <= SCAN_MEAS;
               end else begin
                  idx_reg <= 3'h0;
               end
            end
            SCAN_MEAS: if (done_pulse) state_reg <= SCAN_EVAL;
            SCAN_EVAL: begin
               if (os_cnt_reg + 8'h01 >= os_need) begin
                  os_cnt_reg <= 8'h00;
                  idx_reg <= idx_reg == 3'(N - 1) ? 3'h0 : idx_reg + 3'h1;
                  state_reg <= SCAN_PICK;
               end else begin
                  os_cnt_reg <= os_cnt_reg + 8'h01;
                  state_reg <= SCAN_MEAS;
               end
            end
            default: state_reg <= SCAN_PICK;
         endcase
      end
   end
   assign meas_sel = idx_reg;
   assign meas_start = state_reg == SCAN_MEAS;

   // Per-input state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt_reg <= 32'h00000000;
         touch_reg <= '0;
         cal_reg <= '0;
         hold_reg <= '0;
         over_pat_reg <= '0;
         pat_reg <= 1'b0;
         for (int i = 0; i < N; i++) begin
            base_reg[i] <= 8'h00;
            acc_reg[i] <= 16'h0000;
            avg_n_reg[i] <= 7'h00;
            neg_reg[i] <= 4'h0;
            held_reg[i] <= 8'h00;
            press_cnt_reg[i] <= 4'h0;
            rep_cnt_reg[i] <= 4'h0;
            cal_cnt_reg[i] <= 24'h000000;
         end
      end else begin
         tick_cnt_reg <= tick ? 32'h00000000 : tick_cnt_reg + 32'h00000001;
         touch_reg <= touch_next;
         pat_reg <= pat_now;
         for (int i = 0; i < N; i++) begin
            if (cal_start[i]) begin
               cal_reg[i] <= 1'b1;
               cal_cnt_reg[i] <= 24'h000000;
            end else if (cal_reg[i]) begin
               cal_cnt_reg[i] <= cal_cnt_reg[i] + 24'h000001;
               if (cal_cnt_reg[i] == 24'(RECAL_LEN - 1)) cal_reg[i] <= 1'b0;
            end
            if (!touch_reg[i]) begin
               held_reg[i] <= 8'h00;
               press_cnt_reg[i] <= 4'h0;
               hold_reg[i] <= 1'b0;
               rep_cnt_reg[i] <= 4'h0;
            end else if (tick) begin
               held_reg[i] <= held_reg[i] + 8'h01;
               if (press_cnt_reg[i] >= press_reg[3:0]) hold_reg[i] <= 1'b1;
               else press_cnt_reg[i] <= press_cnt_reg[i] + 4'h1;
               rep_cnt_reg[i] <= irq_set[i] ? 4'h0 : rep_cnt_reg[i] + 4'h1;
            end
         end
         if (state_reg == SCAN_EVAL && !noisy) begin
            over_pat_reg[idx_reg] <= !delta[8] && delta[7:0] >= pcount_reg[7:3];
            neg_reg[idx_reg] <= negative ? neg_reg[idx_reg] + 4'h1 : 4'h0;
            if (cal_reg[idx_reg]) begin
               if (over) cal_cnt_reg[idx_reg] <= 24'h000000;
               base_reg[idx_reg] <= cur_meas;
               acc_reg[idx_reg] <= 16'h0000;
               avg_n_reg[idx_reg] <= 7'h00;
            end else if (!over && !touch_reg[idx_reg]) begin
               if (avg_n_reg[idx_reg] == 7'(1 << touch_pkg::AVG_SHIFT) - 7'h01) begin
                  base_reg[idx_reg] <= 8'((acc_reg[idx_reg] + {8'h00, cur_meas}) >>
                     touch_pkg::AVG_SHIFT);
                  acc_reg[idx_reg] <= 16'h0000;
                  avg_n_reg[idx_reg] <= 7'h00;
               end else begin
                  acc_reg[idx_reg] <= acc_reg[idx_reg] + {8'h00, cur_meas};
                  avg_n_reg[idx_reg] <= avg_n_reg[idx_reg] + 7'h01;
               end
            end
         end
      end
   end

   // Software-visible registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= 8'h00;
         config_reg <= touch_pkg::RST_CONFIG;
         enable_reg <= touch_pkg::RST_ENABLE;
         dur_reg <= touch_pkg::RST_DUR;
         press_reg <= touch_pkg::RST_PRESS;
         sample_reg <= touch_pkg::RST_SAMPLE;
         recal_reg <= touch_pkg::RST_RECAL;
         repeat_reg <= touch_pkg::RST_REPEAT;
         pcount_reg <= touch_pkg::RST_PCOUNT;
         pattern_reg <= touch_pkg::RST_PATTERN;
         negcfg_reg <= touch_pkg::RST_NEGCFG;
         link_reg <= 8'h00;
         status_reg <= 8'h00;
         noise_reg <= 8'h00;
         for (int i = 0; i < N; i++) thresh_reg[i] <= touch_pkg::RST_THRESH;
      end else begin
         if (wr_pend_reg) begin
            case (wr_addr_reg)
               touch_pkg::OFS_CONFIG: config_reg <= wdata;
               touch_pkg::OFS_ENABLE: enable_reg <= wdata & 8'h3F;
               touch_pkg::OFS_DUR: dur_reg <= wdata;
               touch_pkg::OFS_PRESS: press_reg <= wdata;
               touch_pkg::OFS_SAMPLE: sample_reg <= wdata;
               touch_pkg::OFS_REPEAT: repeat_reg <= wdata & 8'h3F;
               touch_pkg::OFS_PCOUNT: pcount_reg <= wdata;
               touch_pkg::OFS_PATTERN: pattern_reg <= wdata & 8'h3F;
               touch_pkg::OFS_NEGCFG: negcfg_reg <= wdata;
               touch_pkg::OFS_LINK: link_reg <= wdata;
               default: begin
                  for (int i = 0; i < N; i++)
                     if (wr_addr_reg == touch_pkg::OFS_THRESH + 8'(i)) thresh_reg[i] <= wdata;
               end
            endcase
         end
         ctrl_reg[touch_pkg::BIT_POL] <= wr_ctrl ? wdata[touch_pkg::BIT_POL] :
            ctrl_reg[touch_pkg::BIT_POL];
         if (irq_any) ctrl_reg[touch_pkg::BIT_INT] <= 1'b1;
         else if (int_clear) ctrl_reg[touch_pkg::BIT_INT] <= 1'b0;
         for (int i = 0; i < N; i++) begin
            if (cal_reg[i] && !cal_start[i] && cal_cnt_reg[i] == 24'(RECAL_LEN - 1))
               recal_reg[i] <= 1'b0;
            else if (wr_recal && wdata[i]) recal_reg[i] <= 1'b1;
            if (irq_set[i] || touch_reg[i]) status_reg[i] <= 1'b1;
            else if (int_clear && !any_touch) status_reg[i] <= 1'b0;
         end
         noise_reg <= (int_clear && !any_touch ? 8'h00 : noise_reg) |
            (state_reg == SCAN_EVAL && s2_reg.lf_noise ? 8'(1) << idx_reg : 8'h00);
      end
   end

   // Alert pin and linked drivers
   assign alert = ctrl_reg[touch_pkg::BIT_INT] ^ ~ctrl_reg[touch_pkg::BIT_POL];
   assign driver_actuate = {touch_reg[link_reg[6:4]] & link_reg[7],
      touch_reg[link_reg[2:0]] & link_reg[3]};
endmodule
`default_nettype wire

// ### test/touch_checker.sv
// Port assertions for the touch sense controller
`timescale 1ns/1ps
`default_nettype none
module touch_checker #(
   parameter int RECAL_LEN = 20,
   parameter int TICK_LEN = 10
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [2:0] meas_sel,
   input wire logic meas_start,
   input wire logic meas_done,
   input wire logic [7:0] meas_count,
   input wire logic lf_noise,
   input wire logic rf_noise,
   input wire logic alert,
   input wire logic [1:0] driver_actuate
);
   logic rd_ctrl_reg;
   logic rd_ctrl_next;
   assign rd_ctrl_next = hsel && htrans[1] && !hwrite && haddr[9:2] == touch_pkg::OFS_CTRL;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_ctrl_reg <= 1'b0;
      end else if (hready) begin
         rd_ctrl_reg <= rd_ctrl_next;
      end
   end
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   a_ready_high: assert property (hreadyout)
      else $error("hreadyout low");
   a_resp_okay: assert property (!hresp)
      else $error("hresp not okay");
   a_sel_range: assert property (meas_start |-> meas_sel < 3'h6)
      else $error("meas_sel out of range");
   a_sel_stable: assert property (meas_start && $past(meas_start) |-> $stable(meas_sel))
      else $error("meas_sel moved during measurement");
   a_done_eval: assert property ($rose(meas_done) |-> ##[1:10] !meas_start)
      else $error("sample not evaluated");
   a_scan_restart: assert property ($fell(meas_start) |-> ##[1:3] meas_start)
      else $error("scan did not continue");
   a_scan_start: assert property ($rose(hresetn) |-> ##[0:3] meas_start)
      else $error("scan did not start");
   a_alert_int: assert property (rd_ctrl_reg |-> alert == ~(hrdata[0] ^ hrdata[1]))
      else $error("alert disagrees with pending flag");
endmodule
bind touch_sense_controller touch_checker #(.RECAL_LEN(RECAL_LEN), .TICK_LEN(TICK_LEN))
   touch_checker_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .meas_sel(meas_sel),
   .meas_start(meas_start), .meas_done(meas_done), .meas_count(meas_count),
   .lf_noise(lf_noise), .rf_noise(rf_noise), .alert(alert), .driver_actuate(driver_actuate));
`default_nettype wire

// ### test/touch_afe_model.sv
// Behavioural sensing front end answering measurement requests
`timescale 1ns/1ps
`default_nettype none
module touch_afe_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [2:0] meas_sel,
   input wire logic meas_start,
   output logic meas_done,
   output logic [7:0] meas_count,
   output logic lf_noise,
   output logic rf_noise
);
   logic [7:0] counts [6] = '{default: 8'h20};
   logic [5:0] lf_mask = 6'h00;
   logic [5:0] rf_mask = 6'h00;
   logic [2:0] seen_q [$];
   logic busy;
   logic slow;
   int wait_cnt;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meas_done <= 1'b0;
         meas_count <= 8'h5A;
         lf_noise <= 1'b0;
         rf_noise <= 1'b0;
         busy <= 1'b0;
         slow <= 1'b0;
         wait_cnt <= 0;
      end else if (meas_start && !busy && !meas_done) begin
         busy <= 1'b1;
         slow <= !slow;
         wait_cnt <= slow ? 6 : 1;
         seen_q.push_back(meas_sel);
      end else if (busy && wait_cnt > 0) begin
         wait_cnt <= wait_cnt - 1;
         meas_count <= counts[meas_sel];
         lf_noise <= lf_mask[meas_sel];
         rf_noise <= rf_mask[meas_sel];
      end else if (busy) begin
         meas_done <= 1'b1;
         busy <= 1'b0;
      end else if (meas_done && !meas_start) begin
         meas_done <= 1'b0;
         meas_count <= ~meas_count;
         lf_noise <= 1'b0;
         rf_noise <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ### test/tb.sv
// Self-checking testbench for the touch sense controller
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, meas_start, meas_done, lf_noise, rf_noise, alert;
   logic [2:0] meas_sel;
   logic [7:0] meas_count;
   logic [1:0] driver_actuate;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   touch_sense_controller #(.RECAL_LEN(200), .TICK_LEN(10)) touch_sense_controller_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .meas_sel(meas_sel), .meas_start(meas_start),
      .meas_done(meas_done), .meas_count(meas_count), .lf_noise(lf_noise),
      .rf_noise(rf_noise), .alert(alert), .driver_actuate(driver_actuate));
   touch_afe_model touch_afe_model_inst (.hclk(hclk), .hresetn(hresetn), .meas_sel(meas_sel),
      .meas_start(meas_start), .meas_done(meas_done), .meas_count(meas_count),
      .lf_noise(lf_noise), .rf_noise(rf_noise));
   initial begin
      forever #50 hclk = ~hclk;
   end
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] ofs, input logic [7:0] wdat,
      output logic [7:0] rdat);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {22'h0, ofs, 2'h0};
      @(posedge hclk iff hreadyout === 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wdat};
      @(posedge hclk iff hreadyout === 1'b1);
      rdat = hrdata[7:0];
   endtask
   task automatic wr(input logic [7:0] ofs, input logic [7:0] wdat);
      logic [7:0] d;
      bus(1'b1, ofs, wdat, d);
   endtask
   task automatic rd_chk(input string what, input logic [7:0] ofs, input logic [7:0] exp);
      logic [7:0] d;
      bus(1'b0, ofs, 8'h00, d);
      check(what, d, exp);
   endtask
   task automatic poll(input string what, input logic [7:0] ofs, input logic [7:0] val);
      logic [7:0] d;
      int n;
      n = 0;
      bus(1'b0, ofs, 8'h00, d);
      while ((d & val) !== val && n < 300) begin
         bus(1'b0, ofs, 8'h00, d);
         n++;
      end
      check(what, d & val, val);
   endtask
   task automatic t_reset();
      check("alert idle", {7'h0, alert}, 8'h01);
      rd_chk("config", touch_pkg::OFS_CONFIG, touch_pkg::RST_CONFIG);
      rd_chk("enable", touch_pkg::OFS_ENABLE, touch_pkg::RST_ENABLE);
      rd_chk("recal", touch_pkg::OFS_RECAL, 8'h00);
      rd_chk("unmapped", 8'h7F, 8'h00);
      wr(touch_pkg::OFS_RECAL, 8'h3F);
      rd_chk("recal busy", touch_pkg::OFS_RECAL, 8'h3F);
      repeat (300) @(posedge hclk);
      rd_chk("recal done", touch_pkg::OFS_RECAL, 8'h00);
      for (int i = 0; i < 6; i++) begin
         rd_chk("baseline", touch_pkg::OFS_BASE + 8'(i), 8'h20);
      end
   endtask
   task automatic t_order();
      wr(touch_pkg::OFS_ENABLE, 8'h15);
      repeat (100) @(posedge hclk);
      touch_afe_model_inst.seen_q.delete();
      repeat (300) @(posedge hclk);
      check("scans", 8'(touch_afe_model_inst.seen_q.size() > 6), 8'h01);
      for (int i = 1; i < touch_afe_model_inst.seen_q.size(); i++) begin
         check("order", {5'h0, touch_afe_model_inst.seen_q[i]},
            touch_afe_model_inst.seen_q[i - 1] == 3'h4 ? 8'h00 :
            {5'h0, touch_afe_model_inst.seen_q[i - 1] + 3'h2});
      end
      wr(touch_pkg::OFS_ENABLE, 8'h3F);
   endtask
   task automatic t_touch();
      wr(touch_pkg::OFS_LINK, 8'h09);
      touch_afe_model_inst.counts[1] = 8'h68;
      poll("touch", touch_pkg::OFS_STATUS, 8'h02);
      rd_chk("pending", touch_pkg::OFS_CTRL, 8'h01);
      check("alert on", {7'h0, alert}, 8'h00);
      check("driver", {6'h0, driver_actuate}, 8'h01);
      wr(touch_pkg::OFS_CTRL, 8'h00);
      rd_chk("status held", touch_pkg::OFS_STATUS, 8'h02);
      rd_chk("base frozen", touch_pkg::OFS_BASE + 8'h01, 8'h20);
      poll("repeat", touch_pkg::OFS_CTRL, 8'h01);
      touch_afe_model_inst.counts[1] = 8'h20;
      repeat (200) @(posedge hclk);
      wr(touch_pkg::OFS_CTRL, 8'h00);
      rd_chk("status clear", touch_pkg::OFS_STATUS, 8'h00);
      check("alert off", {7'h0, alert}, 8'h01);
      check("driver off", {6'h0, driver_actuate}, 8'h00);
   endtask
   task automatic t_release();
      wr(touch_pkg::OFS_REPEAT, 8'h00);
      wr(touch_pkg::OFS_ENABLE, 8'h02);
      touch_afe_model_inst.counts[1] = 8'h68;
      poll("touch", touch_pkg::OFS_STATUS, 8'h02);
      wr(touch_pkg::OFS_CTRL, 8'h00);
      repeat (150) @(posedge hclk);
      rd_chk("no repeat", touch_pkg::OFS_CTRL, 8'h00);
      touch_afe_model_inst.counts[1] = 8'h20;
      poll("release", touch_pkg::OFS_CTRL, 8'h01);
      wr(touch_pkg::OFS_CTRL, 8'h00);
      rd_chk("status clear", touch_pkg::OFS_STATUS, 8'h00);
      wr(touch_pkg::OFS_REPEAT, 8'h3F);
      wr(touch_pkg::OFS_ENABLE, 8'h3F);
   endtask
   task automatic t_noise();
      touch_afe_model_inst.lf_mask = 6'h04;
      touch_afe_model_inst.counts[2] = 8'h70;
      poll("noise flag", touch_pkg::OFS_NOISE, 8'h04);
      rd_chk("lf untouched", touch_pkg::OFS_STATUS, 8'h00);
      touch_afe_model_inst.lf_mask = 6'h00;
      touch_afe_model_inst.rf_mask = 6'h04;
      repeat (200) @(posedge hclk);
      rd_chk("rf untouched", touch_pkg::OFS_STATUS, 8'h00);
      rd_chk("no pending", touch_pkg::OFS_CTRL, 8'h00);
      touch_afe_model_inst.rf_mask = 6'h00;
      touch_afe_model_inst.counts[2] = 8'h20;
   endtask
   task automatic t_polarity();
      wr(touch_pkg::OFS_CTRL, 8'h02);
      @(posedge hclk);
      check("alert high pol", {7'h0, alert}, 8'h00);
      wr(touch_pkg::OFS_CTRL, 8'h00);
      @(posedge hclk);
      check("alert low pol", {7'h0, alert}, 8'h01);
   endtask
   task automatic t_pattern();
      wr(touch_pkg::OFS_PCOUNT, 8'h25);
      for (int i = 0; i < 6; i++) touch_afe_model_inst.counts[i] = 8'h28;
      poll("pattern", touch_pkg::OFS_CTRL, 8'h01);
      touch_afe_model_inst.counts[1] = 8'h68;
      repeat (200) @(posedge hclk);
      rd_chk("pattern blocks", touch_pkg::OFS_STATUS, 8'h00);
      for (int i = 0; i < 6; i++) touch_afe_model_inst.counts[i] = 8'h20;
      repeat (200) @(posedge hclk);
      wr(touch_pkg::OFS_PCOUNT, touch_pkg::RST_PCOUNT);
   endtask
   task automatic t_stuck();
      wr(touch_pkg::OFS_CONFIG, 8'h28);
      touch_afe_model_inst.counts[5] = 8'h68;
      poll("stuck touch", touch_pkg::OFS_STATUS, 8'h20);
      repeat (500) @(posedge hclk);
      rd_chk("stuck recal", touch_pkg::OFS_BASE + 8'h05, 8'h68);
   endtask
   task automatic t_neg();
      touch_afe_model_inst.counts[3] = 8'h10;
      repeat (900) @(posedge hclk);
      rd_chk("neg recal", touch_pkg::OFS_BASE + 8'h03, 8'h10);
   endtask
   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_order();
      t_touch();
      t_release();
      t_noise();
      t_polarity();
      t_pattern();
      t_stuck();
      t_neg();
      close_out();
   end
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 40000) begin
         num_errors++;
         close_out();
      end
   end
endmodule
`default_nettype wire
